// File: smbus_pkg.sv
// shared constants and types for the smbus index block target
package smbus_pkg;

  // target address on the wire, direction bit excluded
  localparam logic [6:0] TARGET_ADDR = 7'h6D;
  // number of implemented configuration bytes
  localparam int NUM_REGS = 9;
  localparam logic [7:0] NUM_REGS_B = 8'h09;
  // reset value of every configuration byte
  localparam logic [7:0] REG_RESET = 8'h00;
  // byte count returned in a read before any write set one
  localparam logic [7:0] COUNT_RESET = 8'h09;
  // byte returned for an index with no register behind it
  localparam logic [7:0] UNMAPPED_BYTE = 8'hFF;
  // write buffer between the link and the register bank
  localparam int WBUF_DEPTH = 8;
  // bit counter value at the end of a byte
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // one pending register write: target index and data
  typedef struct packed {
    logic [7:0] index;
    logic [7:0] data;
  } wr_req_t;

  typedef logic [NUM_REGS-1:0][7:0] cfg_bank_t;

  // bit level activity on the link
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RECV,
    ST_ACK,
    ST_SEND,
    ST_HACK
  } link_state_t;

  // which byte of the transaction is being received
  typedef enum logic [1:0] {
    PH_ADDR,
    PH_INDEX,
    PH_COUNT,
    PH_DATA
  } byte_phase_t;

endpackage : smbus_pkg

// File: smbus_index_target.sv
// smbus index block target with write buffer and configuration bank
`timescale 1ns/10ps
`default_nettype none

// =========================================================
// write buffer
// =========================================================
// small synchronous fifo; full and empty are exact
module wbuf_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wptr_r, rptr_r;
  logic [AW:0] fill_r;
  logic push, pop;

  assign in_ready = (fill_r != (AW+1)'(DEPTH));
  assign out_valid = (fill_r != '0);
  assign out_data = mem_r[rptr_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // storage has no reset; only slots below the fill level are read
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wptr_r] <= in_data;
    end
  end

  // pointers wrap at the depth, which may be any size
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wptr_r <= '0;
      rptr_r <= '0;
      fill_r <= '0;
    end else begin
      if (push) begin
        wptr_r <= (wptr_r == AW'(DEPTH-1)) ? '0 : wptr_r + AW'(1);
      end
      if (pop) begin
        rptr_r <= (rptr_r == AW'(DEPTH-1)) ? '0 : rptr_r + AW'(1);
      end
      if (push && !pop) begin
        fill_r <= fill_r + (AW+1)'(1);
      end else if (pop && !push) begin
        fill_r <= fill_r - (AW+1)'(1);
      end
    end
  end
endmodule : wbuf_fifo

// =========================================================
// link target
// =========================================================
// Behaviour
// - answer only address 1101101, eighth bit direction
// - acknowledge index byte, keep as start index
// - acknowledge the byte count that follows
// - store data bytes at consecutive indices from N
// - acknowledge each data byte individually while the write buffer has room
// - read: repeated start, read address, acknowledged
// - read returns count then bytes from N
module smbus_index_target
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // smbus pins, open drain data
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // register bank side
  input wire logic bank_hold,
  output smbus_pkg::cfg_bank_t cfg_regs
);
  import smbus_pkg::*;

  // true when an index has a register behind it
  function automatic logic reg_hit(input logic [7:0] idx);
    reg_hit = (idx < NUM_REGS_B);
  endfunction : reg_hit

  // byte returned to the host for an index
  function automatic logic [7:0] rd_byte(input cfg_bank_t bank,
                                         input logic [7:0] idx);
    rd_byte = reg_hit(idx) ? bank[idx[3:0]] : UNMAPPED_BYTE;
  endfunction : rd_byte

  logic [1:0] scl_sync_r, sda_sync_r;
  logic scl_d_r, sda_d_r;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  link_state_t state_r;
  byte_phase_t phase_r;
  logic [3:0] bit_r;
  logic [7:0] shift_r, tx_r, ptr_r, count_r, rd_next;
  logic rd_dir_r, host_nack_r, oe_r, push_r;
  wr_req_t push_data_r;
  logic wb_ready, wb_valid;
  wr_req_t wb_data;
  cfg_bank_t cfg_r;

  // pins come from another domain: two flops before any logic
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], scl_i};
      sda_sync_r <= {sda_sync_r[0], sda_i};
      scl_d_r <= scl_sync_r[1];
      sda_d_r <= sda_sync_r[1];
    end
  end

  // edges and bus conditions seen on the synchronised levels
  assign scl_rise = scl_sync_r[1] & ~scl_d_r;
  assign scl_fall = ~scl_sync_r[1] & scl_d_r;
  assign start_cond = scl_sync_r[1] & scl_d_r & sda_d_r & ~sda_sync_r[1];
  assign stop_cond = scl_sync_r[1] & scl_d_r & ~sda_d_r & sda_sync_r[1];
  assign rd_next = rd_byte(cfg_r, ptr_r); // named so its bits can be picked

  // byte level engine; data is only moved while the clock is low,
  // so our own drive never looks like a start or stop
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      phase_r <= PH_ADDR;
      bit_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= 8'h00;
      count_r <= COUNT_RESET;
      rd_dir_r <= 1'b0;
      host_nack_r <= 1'b0;
      oe_r <= 1'b0;
      push_r <= 1'b0;
      push_data_r <= '0;
      sda_o <= 1'b0;
    end else begin
      push_r <= 1'b0;
      sda_o <= 1'b0; // open drain: the pad only ever pulls low
      if (start_cond) begin
        // a start or repeated start always reopens at the address
        state_r <= ST_RECV;
        phase_r <= PH_ADDR;
        bit_r <= 4'h0;
        oe_r <= 1'b0;
      end else if (stop_cond) begin
        state_r <= ST_IDLE;
        oe_r <= 1'b0;
      end else begin
        case (state_r)
          ST_IDLE: oe_r <= 1'b0;
          ST_RECV: begin
            if (scl_rise) begin
              shift_r <= {shift_r[6:0], sda_sync_r[1]};
              bit_r <= bit_r + 4'h1;
            end else if (scl_fall && bit_r == BYTE_BITS) begin
              bit_r <= 4'h0;
              state_r <= ST_ACK;
              oe_r <= 1'b1;
              case (phase_r)
                PH_ADDR: begin
                  if (shift_r[7:1] == TARGET_ADDR) begin
                    rd_dir_r <= shift_r[0];
                  end else begin
                    // another target: stay off the bus until the next start or repeated start
                    state_r <= ST_IDLE;
                    oe_r <= 1'b0;
                  end
                end
                PH_INDEX: ptr_r <= shift_r;
                PH_COUNT: count_r <= shift_r;
                PH_DATA: begin
                  if (wb_ready) begin
                    // unmapped indices are dropped at the bank
                    push_r <= 1'b1;
                    push_data_r <= '{index: ptr_r, data: shift_r};
                    ptr_r <= ptr_r + 8'h01;
                  end else begin
                    // buffer full: refuse the byte rather than lose it
                    state_r <= ST_IDLE;
                    oe_r <= 1'b0;
                  end
                end
                default: begin
                  state_r <= ST_IDLE;
                  oe_r <= 1'b0;
                end
              endcase
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (phase_r == PH_ADDR && rd_dir_r) begin
                // read opens with the byte count
                tx_r <= {count_r[6:0], 1'b0};
                oe_r <= ~count_r[7];
                bit_r <= 4'h1;
                state_r <= ST_SEND;
              end else begin
                oe_r <= 1'b0;
                state_r <= ST_RECV;
                case (phase_r)
                  PH_ADDR: phase_r <= PH_INDEX;
                  PH_INDEX: phase_r <= PH_COUNT;
                  default: phase_r <= PH_DATA;
                endcase
              end
            end
          end
          ST_SEND: begin
            if (scl_fall) begin
              if (bit_r == BYTE_BITS) begin
                oe_r <= 1'b0;
                state_r <= ST_HACK;
              end else begin
                oe_r <= ~tx_r[7];
                tx_r <= {tx_r[6:0], 1'b0};
                bit_r <= bit_r + 4'h1;
              end
            end
          end
          ST_HACK: begin
            if (scl_rise) begin
              host_nack_r <= sda_sync_r[1];
            end else if (scl_fall) begin
              if (host_nack_r) begin
                state_r <= ST_IDLE;
              end else begin
                // next byte from the running index
                tx_r <= {rd_next[6:0], 1'b0};
                oe_r <= ~rd_next[7];
                ptr_r <= ptr_r + 8'h01;
                bit_r <= 4'h1;
                state_r <= ST_SEND;
              end
            end
          end
          default: begin
            state_r <= ST_IDLE;
            oe_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // buffered writes let the bank side stall without slowing the link
  wbuf_fifo #(.WIDTH($bits(wr_req_t)), .DEPTH(WBUF_DEPTH)) u_wbuf (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(push_r),
    .in_ready(wb_ready),
    .in_data(push_data_r),
    .out_valid(wb_valid),
    .out_ready(~bank_hold),
    .out_data(wb_data)
  );

  // register bank update from the buffer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_r <= {NUM_REGS{REG_RESET}};
    end else if (wb_valid && !bank_hold && reg_hit(wb_data.index)) begin
      cfg_r[wb_data.index[3:0]] <= wb_data.data;
    end
  end

  assign sda_oe = oe_r;
  assign cfg_regs = cfg_r;
endmodule : smbus_index_target

`default_nettype wire

// File: smbus_target_props.sv
// port checker for the smbus index target
`timescale 1ns/10ps
`default_nettype none
// ==========
// checker
module smbus_target_props
  import smbus_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // link and bank
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic bank_hold,
  input wire smbus_pkg::cfg_bank_t cfg_regs
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // clock seen high three samples running
  sequence s_scl_high;
    scl_i [*3];
  endsequence
  // data output stays low at all times; the pad is driven only through the enable
  property p_sdao_low; sda_o == 1'b0; endproperty
  a_sdao_low: assert property (p_sdao_low) else $error("sda_o high");
  property p_rst_quiet;
    $fell(sys_rst) |-> !sda_oe && cfg_regs == '0;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("reset");
  property p_idle; scl_i [*8] |-> !sda_oe; endproperty
  a_idle: assert property (p_idle) else $error("idle drive");
  property p_oe_low; $changed(sda_oe) |-> !$past(scl_i, 2); endproperty
  a_oe_low: assert property (p_oe_low) else $error("oe timing");
  property p_oe_stable; s_scl_high |=> $stable(sda_oe); endproperty
  a_oe_stable: assert property (p_oe_stable) else $error("oe moved");
  property p_ack_len; $rose(sda_oe) |-> sda_oe [*6]; endproperty
  a_ack_len: assert property (p_ack_len) else $error("ack short");
  property p_rise; $rose(scl_i) |-> ##2 $stable(sda_oe) [*2]; endproperty
  a_rise: assert property (p_rise) else $error("oe at rise");
  property p_hold;
    $changed(cfg_regs) |-> !($past(bank_hold) && $past(bank_hold, 2));
  endproperty
  a_hold: assert property (p_hold) else $error("bank moved");
endmodule : smbus_target_props
bind smbus_index_target smbus_target_props u_props (.clk, .sys_rst, .scl_i,
  .sda_o, .sda_oe, .bank_hold, .cfg_regs);
`default_nettype wire

// File: smbus_host_model.sv
// smbus host model driving clock and data
`timescale 1ns/10ps
`default_nettype none
// ==========
// host
module smbus_host_model (
  // clock
  input wire logic clk,
  // link
  input wire logic sda_oe,
  output logic scl,
  output wire logic sda
);
  logic pull_low = 1'b0;
  // open drain with pull-up, a released line reads high
  assign sda = !(pull_low || sda_oe);
  initial scl = 1'b1;
  // data moves one clock after scl falls, so no false start or stop
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_clk
  task automatic start();
    wait_clk(1);
    pull_low = 1'b0;
    wait_clk(3);
    scl = 1'b1;
    wait_clk(4);
    pull_low = 1'b1;
    wait_clk(4);
    scl = 1'b0;
  endtask : start
  task automatic stop();
    wait_clk(1);
    pull_low = 1'b1;
    wait_clk(3);
    scl = 1'b1;
    wait_clk(4);
    pull_low = 1'b0;
    wait_clk(4);
  endtask : stop
  task automatic bit_io(input logic b, output logic r);
    wait_clk(1);
    pull_low = !b;
    wait_clk(3);
    scl = 1'b1;
    wait_clk(4);
    r = sda;
    scl = 1'b0;
  endtask : bit_io
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : wr_byte
  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nack, r);
  endtask : rd_byte
endmodule : smbus_host_model
`default_nettype wire

// File: smbus_index_block_write_bench.sv
// self-checking bench for the smbus index target
`timescale 1ns/10ps
`default_nettype none
// ==========
// bench
module smbus_index_block_write_bench;
  import smbus_pkg::*;
  localparam logic [7:0] WR_A = {TARGET_ADDR, 1'b0};
  localparam logic [7:0] RD_A = {TARGET_ADDR, 1'b1};
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic bank_hold = 1'b0;
  wire logic scl;
  wire logic sda;
  logic sda_o;
  logic sda_oe;
  cfg_bank_t cfg_regs;
  int err_total = 0;
  int total_checks = 0;
  logic ack;
  logic [7:0] rd;
  always #25 clk = !clk;
  smbus_host_model i_host (.clk, .sda_oe, .scl, .sda);
  smbus_index_target i_dut (.clk, .sys_rst, .scl_i(scl), .sda_i(sda),
    .sda_o, .sda_oe, .bank_hold, .cfg_regs);
  task automatic chk(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask : chk
  task automatic send(input logic [7:0] b, input logic exp_ack);
    i_host.wr_byte(b, ack);
    chk("ack", {7'h00, exp_ack}, {7'h00, ack});
  endtask : send
  task automatic head(input logic [7:0] idx, input logic [7:0] cnt);
    i_host.start();
    send(WR_A, 1'b1);
    send(idx, 1'b1);
    send(cnt, 1'b1);
  endtask : head
  task automatic t_single();
    head(8'h02, 8'h01);
    send(8'hAB, 1'b1);
    i_host.stop();
    i_host.wait_clk(4);
    chk("cfg2", 8'hAB, cfg_regs[2]);
    $display("done single");
  endtask : t_single
  task automatic t_span();
    head(8'h07, 8'h03);
    send(8'h5A, 1'b1);
    send(8'hC3, 1'b1);
    send(8'h3C, 1'b1);
    i_host.stop();
    i_host.wait_clk(4);
    chk("cfg7", 8'h5A, cfg_regs[7]);
    chk("cfg8", 8'hC3, cfg_regs[8]);
    chk("cfg2", 8'hAB, cfg_regs[2]);
    chk("cfg1", 8'h00, cfg_regs[1]);
    $display("done span");
  endtask : t_span
  task automatic t_bad();
    i_host.start();
    send({7'h6C, 1'b0}, 1'b0);
    send(8'h00, 1'b0);
    i_host.stop();
    chk("cfg0", 8'h00, cfg_regs[0]);
    $display("done bad address");
  endtask : t_bad
  task automatic t_read();
    i_host.start();
    send(WR_A, 1'b1);
    send(8'h07, 1'b1);
    i_host.start();
    send(RD_A, 1'b1);
    i_host.rd_byte(1'b0, rd);
    chk("count", 8'h03, rd);
    i_host.rd_byte(1'b0, rd);
    chk("rd7", 8'h5A, rd);
    i_host.rd_byte(1'b1, rd);
    chk("rd8", 8'hC3, rd);
    i_host.stop();
    $display("done read");
  endtask : t_read
  task automatic t_full();
    bank_hold = 1'b1;
    head(8'h00, 8'h09);
    for (int k = 0; k < 9; k++) send(8'h10 + 8'(k), k < 8);
    i_host.stop();
    chk("held", 8'h00, cfg_regs[0]);
    bank_hold = 1'b0;
    i_host.wait_clk(20);
    for (int k = 0; k < 8; k++) begin
      chk("fill", 8'h10 + 8'(k), cfg_regs[k]);
    end
    chk("cfg8", 8'hC3, cfg_regs[8]);
    $display("done full buffer");
  endtask : t_full
  // mid-run reset: bank, read count and unmapped read back to defaults
  task automatic t_reset();
    i_host.wait_clk(1);
    sys_rst = 1'b1;
    i_host.wait_clk(3);
    sys_rst = 1'b0;
    i_host.wait_clk(3);
    for (int k = 0; k < NUM_REGS; k++) chk("rst2", REG_RESET, cfg_regs[k]);
    i_host.start();
    send(WR_A, 1'b1);
    send(8'h08, 1'b1);
    i_host.start();
    send(RD_A, 1'b1);
    i_host.rd_byte(1'b0, rd);
    chk("count0", COUNT_RESET, rd);
    i_host.rd_byte(1'b0, rd);
    chk("rd8", REG_RESET, rd);
    i_host.rd_byte(1'b1, rd);
    chk("rd9", UNMAPPED_BYTE, rd);
    i_host.stop();
    $display("done reset");
  endtask : t_reset
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  // main sequence
  initial begin
    i_host.wait_clk(3);
    sys_rst = 1'b0;
    i_host.wait_clk(3);
    for (int k = 0; k < NUM_REGS; k++) chk("rst", REG_RESET, cfg_regs[k]);
    t_single();
    t_span();
    t_bad();
    t_read();
    t_full();
    t_reset();
    finish_test();
  end
  // about 2800 clocks needed, so this only cuts a hang
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    finish_test();
  end
endmodule : smbus_index_block_write_bench
`default_nettype wire
